// file: camac_loader_pkg.sv
// Constants and types for the listener-loaded dataway bridge
`default_nettype none
package camac_loader_pkg;
  localparam int CLOCK_MHZ = 200;
  localparam int T_S1_ON_NS = 400;
  localparam int T_S1_OFF_NS = 600;
  localparam int T_S2_ON_NS = 750;
  localparam int T_S2_OFF_NS = 850;
  localparam int T_CYCLE_NS = 1000;
  localparam int T_FAST_GAP_NS = 2000;
  localparam int T_SLOW_GAP_NS = 40000;
  localparam int S1_ON_CYC = (T_S1_ON_NS * CLOCK_MHZ + 999) / 1000;
  localparam int S1_OFF_CYC = (T_S1_OFF_NS * CLOCK_MHZ + 999) / 1000;
  localparam int S2_ON_CYC = (T_S2_ON_NS * CLOCK_MHZ + 999) / 1000;
  localparam int S2_OFF_CYC = (T_S2_OFF_NS * CLOCK_MHZ + 999) / 1000;
  localparam int CYCLE_CYC = (T_CYCLE_NS * CLOCK_MHZ + 999) / 1000;
  localparam int FAST_GAP_CYC = (T_FAST_GAP_NS * CLOCK_MHZ + 999) / 1000;
  localparam int SLOW_GAP_CYC = (T_SLOW_GAP_NS * CLOCK_MHZ + 999) / 1000;
  localparam int GAP_W = 14;
  // Bus command groups
  localparam logic [1:0] LISTEN_GROUP = 2'h1;
  localparam logic [1:0] TALK_GROUP = 2'h2;
  localparam logic [4:0] UNADDR_CODE = 5'h1f;
  // Register indices in load order
  localparam logic [2:0] REG_FUNCTION = 3'h0;
  localparam logic [2:0] REG_SUBADDR = 3'h1;
  localparam logic [2:0] REG_STATION = 3'h2;
  localparam logic [2:0] REG_DATA_LO = 3'h3;
  localparam logic [2:0] REG_DATA_MID = 3'h4;
  localparam logic [2:0] REG_DATA_HI = 3'h5;
  localparam logic [2:0] REG_COUNT = 3'h6;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Setup byte fields
  localparam int SETUP_FLAG_BIT = 7;
  localparam int SETUP_INIT_BIT = 6;
  localparam int SETUP_CLEAR_BIT = 5;
  localparam int SETUP_INHIBIT_BIT = 4;
  localparam int SETUP_SLOW_BIT = 3;
  localparam int SETUP_BLOCK_BIT = 2;
  localparam int SETUP_WIDTH_LSB = 0;
  // Status byte fields and the write function group
  localparam int STATUS_X_BIT = 0;
  localparam int STATUS_Q_BIT = 2;
  localparam logic [1:0] WRITE_GROUP = 2'h2;

  typedef struct packed {
    logic init;
    logic clear;
    logic inhibit;
    logic slow;
    logic block;
    logic [1:0] width;
  } mode_type;
  localparam mode_type MODE_RESET = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h1};

  typedef struct packed {
    logic [4:0] n;
    logic [3:0] a;
    logic [4:0] f;
    logic [23:0] w;
    logic c;
    logic z;
    logic i;
  } dw_cmd_type;

  typedef struct packed {
    logic q;
    logic x;
    logic [23:0] r;
  } dw_resp_type;

  typedef enum logic [2:0] {
    TK_IDLE = 3'h0, TK_CYCLE = 3'h1, TK_PICK = 3'h3, TK_RFD = 3'h2,
    TK_ACK = 3'h6, TK_STEP = 3'h7, TK_GAP = 3'h5
  } talk_state_type;

  typedef enum logic [1:0] {DW_IDLE = 2'h0, DW_RUN = 2'h1, DW_END = 2'h3} dw_state_type;
endpackage : camac_loader_pkg
`default_nettype wire

// file: dataway_cycle_engine.sv
// One dataway cycle: address, strobes, clear/initialise and response capture
`default_nettype none
module dataway_cycle_engine import camac_loader_pkg::*; (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic go,
  input wire dw_cmd_type cmd,
  input wire logic [23:0] dw_r,
  input wire logic dw_q,
  input wire logic dw_x,
  output logic [4:0] dw_n,
  output logic [3:0] dw_a,
  output logic [4:0] dw_f,
  output logic [23:0] dw_w,
  output logic dw_busy,
  output logic dw_s1,
  output logic dw_s2,
  output logic dw_c,
  output logic dw_z,
  output logic dw_i,
  output logic done,
  output dw_resp_type resp
);
  localparam int DONE_LAT = CYCLE_CYC + 1;
  dw_state_type state_q;
  dw_cmd_type cmd_q;
  logic [7:0] cnt_q;
  logic [25:0] in_s1_q, in_s2_q, in_s3_q, in_q;
  logic run, in_s1win, in_s2win, sample, is_write;

  assign run = state_q == DW_RUN;
  assign in_s1win = run && cnt_q >= 8'(S1_ON_CYC) && cnt_q < 8'(S1_OFF_CYC);
  assign in_s2win = run && cnt_q >= 8'(S2_ON_CYC) && cnt_q < 8'(S2_OFF_CYC);
  // Late in S1 so the three-stage input filter has settled
  assign sample = run && cnt_q == 8'(S1_OFF_CYC - 1);
  assign is_write = cmd_q.f[4:3] == WRITE_GROUP;
  assign done = state_q == DW_END;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      in_s1_q <= '0;
      in_s2_q <= '0;
      in_s3_q <= '0;
      in_q <= '0;
    end else begin
      in_s1_q <= {dw_q, dw_x, dw_r};
      in_s2_q <= in_s1_q;
      in_s3_q <= in_s2_q;
      in_q <= (in_s2_q & in_s3_q) | (in_q & (in_s2_q | in_s3_q));
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= DW_IDLE;
      cnt_q <= '0;
      cmd_q <= '0;
      resp <= '0;
    end else begin
      case (state_q)
        DW_IDLE: begin
          cnt_q <= '0;
          if (go) begin
            cmd_q <= cmd;
            state_q <= DW_RUN;
          end
        end
        DW_RUN: begin
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q == 8'(CYCLE_CYC - 1)) state_q <= DW_END;
        end
        default: state_q <= DW_IDLE;
      endcase
      if (sample) resp <= in_q;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dw_n <= '0;
      dw_a <= '0;
      dw_f <= '0;
      dw_w <= '0;
      dw_busy <= 1'b0;
      dw_s1 <= 1'b0;
      dw_s2 <= 1'b0;
      dw_c <= 1'b0;
      dw_z <= 1'b0;
      dw_i <= 1'b0;
    end else begin
      dw_n <= run ? cmd_q.n : 5'h00;
      dw_a <= run ? cmd_q.a : 4'h0;
      dw_f <= run ? cmd_q.f : 5'h00;
      dw_w <= (run && is_write) ? cmd_q.w : 24'h000000;
      dw_busy <= run;
      dw_s1 <= in_s1win;
      dw_s2 <= in_s2win;
      dw_c <= in_s2win && cmd_q.c;
      dw_z <= in_s2win && cmd_q.z;
      // Inhibit level only changes when a cycle is issued
      dw_i <= cmd_q.i;
    end
  end

  a_strobe_in_busy: assert property (@(posedge clock) disable iff (!rst_b)
    dw_s1 || dw_s2 |-> dw_busy) else $error("strobe outside busy");
  a_cycle_done_time: assert property (@(posedge clock) disable iff (!rst_b)
    (go && state_q == DW_IDLE) |-> ##DONE_LAT done) else $error("cycle length wrong");
  a_write_lines_map: assert property (@(posedge clock) disable iff (!rst_b)
    (go && state_q == DW_IDLE && cmd.f[4:3] == WRITE_GROUP) |-> ##2
    (dw_w[7:0] == $past(cmd.w[7:0], 2) && dw_w[23:16] == $past(cmd.w[23:16], 2)))
    else $error("write lines not from data bytes");
endmodule : dataway_cycle_engine
`default_nettype wire

// file: gpib_camac_loader.sv
// Bus-side listener loader, talker read-back and dataway cycle control
`default_nettype none
module gpib_camac_loader import camac_loader_pkg::*; #(
  parameter int SLOW_GAP_CYCLES = SLOW_GAP_CYC
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [7:0] dio_in_b,
  output logic [7:0] dio_out_b,
  output logic dio_oe,
  input wire logic dav_in_b,
  output logic dav_out_b,
  output logic dav_oe,
  input wire logic nrfd_in_b,
  output logic nrfd_out_b,
  output logic nrfd_oe,
  input wire logic ndac_in_b,
  output logic ndac_out_b,
  output logic ndac_oe,
  input wire logic eoi_in_b,
  output logic eoi_out_b,
  output logic eoi_oe,
  input wire logic atn_in_b,
  input wire logic ifc_in_b,
  input wire logic [4:0] addr_sw,
  input wire logic byte_order_rev,
  output logic [4:0] dw_n,
  output logic [3:0] dw_a,
  output logic [4:0] dw_f,
  output logic [23:0] dw_w,
  output logic dw_busy,
  output logic dw_s1,
  output logic dw_s2,
  output logic dw_c,
  output logic dw_z,
  output logic dw_i,
  input wire logic [23:0] dw_r,
  input wire logic dw_q,
  input wire logic dw_x,
  output logic talk_active,
  output logic listen_active
);
  localparam int SW = 19;
  localparam int GAP_MAX = 8200;

  function automatic logic [7:0] pick_byte(input logic [23:0] w, input logic [1:0] n,
                                           input logic [1:0] k, input logic rev);
    logic [1:0] s;
    logic [23:0] sh;
    s = k;
    if (rev && n != 2'h1 && k != 2'h2) s = {1'b0, ~k[0]};
    sh = w >> {s, 3'h0};
    return sh[7:0];
  endfunction : pick_byte

  // Pin filter: three stages, a change counts once stages two and three agree
  logic [SW-1:0] pin_raw, pin_s1_q, pin_s2_q, pin_s3_q, pin_q;
  assign pin_raw = {~dio_in_b, ~dav_in_b, ~nrfd_in_b, ~ndac_in_b, ~atn_in_b, ~ifc_in_b,
                    addr_sw, byte_order_rev};
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
      pin_q <= '0;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_q <= (pin_s2_q & pin_s3_q) | (pin_q & (pin_s2_q | pin_s3_q));
    end
  end

  logic [7:0] bus_byte;
  logic dav_s, nrfd_s, ndac_s, atn_s, ifc_s, rev_s;
  logic [4:0] addr_s;
  assign bus_byte = pin_q[18:11];
  assign dav_s = pin_q[10];
  assign nrfd_s = pin_q[9];
  assign ndac_s = pin_q[8];
  assign atn_s = pin_q[7];
  assign ifc_s = pin_q[6];
  assign addr_s = pin_q[5:1];
  assign rev_s = pin_q[0];

  // Acceptor handshake, active while listening or while commands are sent
  logic listen_q, talk_q, ac_wait_q, rx_valid_q, rx_atn_q;
  logic [7:0] rx_q;
  logic participate, take;
  assign participate = atn_s || listen_q;
  assign take = participate && !ac_wait_q && dav_s;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ac_wait_q <= 1'b0;
      rx_valid_q <= 1'b0;
      rx_atn_q <= 1'b0;
      rx_q <= '0;
    end else begin
      ac_wait_q <= participate && (take || (ac_wait_q && dav_s));
      rx_valid_q <= take;
      if (take) begin
        rx_q <= bus_byte;
        rx_atn_q <= atn_s;
      end
    end
  end
  assign nrfd_out_b = 1'b0;
  assign ndac_out_b = 1'b0;
  assign nrfd_oe = participate && ac_wait_q;
  assign ndac_oe = participate && !ac_wait_q;

  // Addressing commands
  logic cmd_valid, my_listen, unlisten, my_talk, other_talk, restart;
  assign cmd_valid = rx_valid_q && rx_atn_q;
  assign unlisten = cmd_valid && rx_q[6:0] == {LISTEN_GROUP, UNADDR_CODE};
  assign my_listen = cmd_valid && rx_q[6:5] == LISTEN_GROUP && rx_q[4:0] == addr_s && !unlisten;
  assign my_talk = cmd_valid && rx_q[6:5] == TALK_GROUP && rx_q[4:0] == addr_s
                   && rx_q[4:0] != UNADDR_CODE;
  assign other_talk = cmd_valid && rx_q[6:5] == TALK_GROUP && !my_talk;
  assign restart = ifc_s || my_listen || unlisten || my_talk;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      listen_q <= 1'b0;
      talk_q <= 1'b0;
    end else begin
      listen_q <= !(ifc_s || unlisten || my_talk) && (my_listen || listen_q);
      talk_q <= !(ifc_s || other_talk || my_listen) && (my_talk || talk_q);
    end
  end
  assign talk_active = talk_q;
  assign listen_active = listen_q;

  // Register loading
  logic [2:0] ptr_q;
  logic [7:0] regs_q [REG_COUNT];
  logic store_en, is_setup, wr_setup;
  logic [REG_COUNT-1:0] wr_reg;
  mode_type mode_q;
  logic dw_done;
  assign store_en = rx_valid_q && !rx_atn_q && listen_q && ptr_q != REG_COUNT;
  assign is_setup = rx_q[SETUP_FLAG_BIT];
  assign wr_setup = store_en && ptr_q == REG_FUNCTION && is_setup;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) ptr_q <= REG_FUNCTION;
    else if (restart) ptr_q <= REG_FUNCTION;
    else if (store_en) ptr_q <= ptr_q + 3'h1;
  end

  for (genvar g = 0; g < REG_COUNT; g++) begin : g_reg
    assign wr_reg[g] = store_en && ptr_q == 3'(g) && !(g == 0 && is_setup);
    always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) regs_q[g] <= REG_RESET;
      else if (wr_reg[g]) regs_q[g] <= rx_q;
    end
  end

  logic [7:0] function_or_setup, module_subaddress, station_slot_number;
  logic [7:0] write_data_low, write_data_middle, write_data_high;
  assign function_or_setup = regs_q[REG_FUNCTION];
  assign module_subaddress = regs_q[REG_SUBADDR];
  assign station_slot_number = regs_q[REG_STATION];
  assign write_data_low = regs_q[REG_DATA_LO];
  assign write_data_middle = regs_q[REG_DATA_MID];
  assign write_data_high = regs_q[REG_DATA_HI];

  // Clear and initialise drop after the next cycle; a new setup write wins
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) mode_q <= MODE_RESET;
    else if (wr_setup) begin
      mode_q.init <= rx_q[SETUP_INIT_BIT];
      mode_q.clear <= rx_q[SETUP_CLEAR_BIT];
      mode_q.inhibit <= rx_q[SETUP_INHIBIT_BIT];
      mode_q.slow <= rx_q[SETUP_SLOW_BIT];
      mode_q.block <= rx_q[SETUP_BLOCK_BIT];
      mode_q.width <= rx_q[SETUP_WIDTH_LSB +: 2];
    end else if (dw_done) begin
      mode_q.init <= 1'b0;
      mode_q.clear <= 1'b0;
    end
  end

  dw_cmd_type dw_cmd;
  dw_resp_type dw_resp;
  assign dw_cmd = '{n: station_slot_number[4:0], a: module_subaddress[3:0],
                    f: function_or_setup[4:0],
                    w: {write_data_high, write_data_middle, write_data_low},
                    c: mode_q.clear, z: mode_q.init, i: mode_q.inhibit};

  // Talker read-back
  talk_state_type tk_q;
  logic [1:0] idx_q, nbytes;
  logic [23:0] word_q;
  dw_resp_type resp_q;
  logic first_q, hold_q, eoi_q, final_q, dw_go_q;
  logic [7:0] out_b_q, status_byte, pick_data;
  logic [GAP_W-1:0] gap_q;
  logic last_idx, send_status, need_cycle, pick_eoi, abort;
  assign nbytes = (mode_q.width == 2'h0) ? 2'h1 : mode_q.width;
  assign last_idx = idx_q == nbytes - 2'h1;
  assign status_byte = (8'(resp_q.x) << STATUS_X_BIT) | (8'(resp_q.q) << STATUS_Q_BIT);
  assign send_status = (!mode_q.block && idx_q == nbytes)
                       || (mode_q.block && first_q && !resp_q.q);
  // The last byte of a block word waits for the next cycle's Q to know its EOI
  assign need_cycle = mode_q.block && !send_status && last_idx && !hold_q;
  assign pick_eoi = send_status || (mode_q.block && last_idx && hold_q && !resp_q.q);
  assign pick_data = send_status ? status_byte
                     : pick_byte(word_q, nbytes, idx_q, rev_s);
  assign abort = !talk_q || ifc_s;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tk_q <= TK_IDLE;
      idx_q <= '0;
      word_q <= '0;
      resp_q <= '0;
      first_q <= 1'b0;
      hold_q <= 1'b0;
      eoi_q <= 1'b0;
      final_q <= 1'b0;
      out_b_q <= 8'hff;
      gap_q <= '0;
      dw_go_q <= 1'b0;
    end else begin
      dw_go_q <= 1'b0;
      if (abort && tk_q != TK_IDLE) tk_q <= TK_IDLE;
      else begin
        case (tk_q)
          TK_IDLE: if (my_talk) begin
            tk_q <= TK_CYCLE;
            dw_go_q <= 1'b1;
            first_q <= 1'b1;
            hold_q <= 1'b0;
            idx_q <= '0;
          end
          TK_CYCLE: if (dw_done) begin
            resp_q <= dw_resp;
            if (first_q) word_q <= dw_resp.r;
            else hold_q <= 1'b1;
            tk_q <= TK_PICK;
          end
          TK_PICK: if (!atn_s) begin
            first_q <= 1'b0;
            if (need_cycle) begin
              gap_q <= mode_q.slow ? GAP_W'(SLOW_GAP_CYCLES) : GAP_W'(FAST_GAP_CYC);
              tk_q <= TK_GAP;
            end else begin
              out_b_q <= ~pick_data;
              eoi_q <= pick_eoi;
              final_q <= pick_eoi;
              tk_q <= TK_RFD;
            end
          end
          TK_GAP: if (gap_q == '0) begin
            dw_go_q <= 1'b1;
            tk_q <= TK_CYCLE;
          end else gap_q <= gap_q - GAP_W'(1);
          TK_RFD: if (atn_s) tk_q <= TK_PICK;
            else if (!nrfd_s) tk_q <= TK_ACK;
          TK_ACK: if (atn_s) tk_q <= TK_PICK;
            else if (!ndac_s) tk_q <= TK_STEP;
          TK_STEP: if (final_q) tk_q <= TK_IDLE;
            else begin
              if (hold_q) begin
                word_q <= resp_q.r;
                idx_q <= '0;
                hold_q <= 1'b0;
              end else idx_q <= idx_q + 2'h1;
              tk_q <= TK_PICK;
            end
          default: tk_q <= TK_IDLE;
        endcase
      end
    end
  end

  // Byte is presented one state before DAV so the data lines settle first
  assign dio_out_b = out_b_q;
  assign dio_oe = tk_q == TK_RFD || tk_q == TK_ACK;
  assign dav_out_b = 1'b0;
  assign dav_oe = tk_q == TK_ACK;
  assign eoi_out_b = 1'b0;
  assign eoi_oe = dio_oe && eoi_q;

  dataway_cycle_engine u_engine (
    .clock(clock), .rst_b(rst_b), .go(dw_go_q), .cmd(dw_cmd),
    .dw_r(dw_r), .dw_q(dw_q), .dw_x(dw_x),
    .dw_n(dw_n), .dw_a(dw_a), .dw_f(dw_f), .dw_w(dw_w), .dw_busy(dw_busy),
    .dw_s1(dw_s1), .dw_s2(dw_s2), .dw_c(dw_c), .dw_z(dw_z), .dw_i(dw_i),
    .done(dw_done), .resp(dw_resp)
  );

  a_pointer_advance: assert property (@(posedge clock) disable iff (!rst_b)
    (store_en && !restart) |=> ptr_q == $past(ptr_q) + 3'h1) else $error("pointer stuck");
  a_first_byte_func: assert property (@(posedge clock) disable iff (!rst_b)
    (store_en && ptr_q == REG_FUNCTION && !is_setup) |=> function_or_setup == $past(rx_q))
    else $error("function byte lost");
  a_station_order: assert property (@(posedge clock) disable iff (!rst_b)
    (store_en && ptr_q == REG_STATION) |=> station_slot_number == $past(rx_q))
    else $error("station byte misplaced");
  a_regs_hold: assert property (@(posedge clock) disable iff (!rst_b)
    !store_en |=> $stable(write_data_high) && $stable(module_subaddress))
    else $error("register changed without load");
  a_pointer_restart: assert property (@(posedge clock) disable iff (!rst_b)
    restart |=> ptr_q == REG_FUNCTION) else $error("pointer not restarted");
  a_listen_gate: assert property (@(posedge clock) disable iff (!rst_b)
    !listen_q |-> wr_reg == '0) else $error("byte stored while not listener");
  a_overflow_drop: assert property (@(posedge clock) disable iff (!rst_b)
    (ptr_q == REG_COUNT && !restart) |=> ptr_q == REG_COUNT && $stable(write_data_high))
    else $error("overflow byte stored");
  a_eoi_with_data: assert property (@(posedge clock) disable iff (!rst_b)
    eoi_oe |-> dio_oe) else $error("eoi without data");
  a_block_stop: assert property (@(posedge clock) disable iff (!rst_b)
    (tk_q == TK_STEP && final_q && !abort) |=> tk_q == TK_IDLE && !dw_go_q)
    else $error("block did not stop");
  a_gap_bound: assert property (@(posedge clock) disable iff (!rst_b)
    tk_q == TK_GAP |-> gap_q <= GAP_W'(GAP_MAX)) else $error("gap count out of range");

  c_single_word: cover property (@(posedge clock) disable iff (!rst_b)
    tk_q == TK_STEP && final_q && !mode_q.block);
  c_block_word: cover property (@(posedge clock) disable iff (!rst_b)
    tk_q == TK_STEP && hold_q && !final_q);
  c_slow_gap: cover property (@(posedge clock) disable iff (!rst_b)
    tk_q == TK_GAP && mode_q.slow);
endmodule : gpib_camac_loader
`default_nettype wire

// file: gpib_ctl_model.sv
// Bus controller model: sources commands and data, accepts talker bytes
`default_nettype none
module gpib_ctl_model (
  input wire logic clock,
  input wire logic [7:0] dio_b,
  input wire logic dav_b,
  input wire logic nrfd_b,
  input wire logic ndac_b,
  input wire logic eoi_b,
  output logic [7:0] ctl_dio_b,
  output logic ctl_dav_b,
  output logic ctl_nrfd_b,
  output logic ctl_ndac_b,
  output logic atn_b,
  output logic ifc_b
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    ctl_dio_b = 8'hff;
    ctl_dav_b = 1'b1;
    ctl_nrfd_b = 1'b1;
    ctl_ndac_b = 1'b1;
    atn_b = 1'b1;
    ifc_b = 1'b1;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step
  task automatic step_k(inout int k);
    step(1);
    k++;
  endtask : step_k
  // Bounded waits: with no acceptor on the bus the handshake just gives up
  task automatic put_byte(input logic [7:0] d, input logic atn);
    int k;
    atn_b = ~atn;
    ctl_dio_b = ~d;
    step(6);
    k = 0;
    while (nrfd_b !== 1'b1 && k < 400) step_k(k);
    ctl_dav_b = 1'b0;
    k = 0;
    while (ndac_b !== 1'b1 && k < 400) step_k(k);
    ctl_dav_b = 1'b1;
    k = 0;
    while (ndac_b !== 1'b0 && k < 40) step_k(k);
    ctl_dio_b = 8'hff;
    atn_b = 1'b1;
    step(2);
  endtask : put_byte
  // NDAC stays held between bytes so the next byte is never lost
  task automatic get_byte(output logic [7:0] d, output logic eoi);
    int k;
    ctl_ndac_b = 1'b0;
    ctl_nrfd_b = 1'b1;
    k = 0;
    while (dav_b !== 1'b0 && k < 2000) step_k(k);
    step(1);
    d = ~dio_b;
    eoi = ~eoi_b;
    ctl_nrfd_b = 1'b0;
    ctl_ndac_b = 1'b1;
    k = 0;
    while (dav_b !== 1'b1 && k < 400) step_k(k);
    ctl_ndac_b = 1'b0;
    step(1);
  endtask : get_byte
  task automatic idle;
    ctl_nrfd_b = 1'b1;
    ctl_ndac_b = 1'b1;
    step(2);
  endtask : idle
endmodule : gpib_ctl_model
`default_nettype wire

// file: gpib_to_camac_command_loader_tb_top.sv
// Testbench: loads registers through the bus model, checks dataway and read-back
`default_nettype none
module gpib_to_camac_command_loader_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic byte_order_rev = 1'b0;
  logic [23:0] dw_r = 24'h000000;
  logic dw_q = 1'b0;
  logic dw_x = 1'b0;
  logic [7:0] dio_out_b, ctl_dio_b;
  logic dio_oe, dav_oe, nrfd_oe, ndac_oe, eoi_oe, dw_busy, talk_active, listen_active;
  logic dav_out_b, nrfd_out_b, ndac_out_b, eoi_out_b, ctl_dav_b, ctl_nrfd_b, ctl_ndac_b;
  logic atn_b, ifc_b;
  logic [4:0] dw_n, dw_f;
  logic [3:0] dw_a;
  logic [23:0] dw_w;
  logic dw_s1, dw_s2, dw_c, dw_z, dw_i;
  int error_cnt = 0;
  int tests_run = 0;
  // Open-drain lines with pull-ups: low when any party drives low
  wire [7:0] dio_b = (dio_oe ? dio_out_b : 8'hff) & ctl_dio_b;
  wire dav_b = (dav_oe ? dav_out_b : 1'b1) & ctl_dav_b;
  wire nrfd_b = (nrfd_oe ? nrfd_out_b : 1'b1) & ctl_nrfd_b;
  wire ndac_b = (ndac_oe ? ndac_out_b : 1'b1) & ctl_ndac_b;
  wire eoi_b = eoi_oe ? eoi_out_b : 1'b1;
  always #2.5 clock = ~clock;
  gpib_camac_loader #(.SLOW_GAP_CYCLES(20)) i_dut (.clock(clock), .rst_b(rst_b),
    .dio_in_b(dio_b), .dio_out_b(dio_out_b), .dio_oe(dio_oe), .dav_in_b(dav_b),
    .dav_out_b(dav_out_b), .dav_oe(dav_oe), .nrfd_in_b(nrfd_b), .nrfd_out_b(nrfd_out_b),
    .nrfd_oe(nrfd_oe), .ndac_in_b(ndac_b), .ndac_out_b(ndac_out_b), .ndac_oe(ndac_oe),
    .eoi_in_b(eoi_b), .eoi_out_b(eoi_out_b), .eoi_oe(eoi_oe), .atn_in_b(atn_b),
    .ifc_in_b(ifc_b), .addr_sw(5'h05), .byte_order_rev(byte_order_rev), .dw_n(dw_n),
    .dw_a(dw_a), .dw_f(dw_f), .dw_w(dw_w), .dw_busy(dw_busy), .dw_s1(dw_s1), .dw_s2(dw_s2),
    .dw_c(dw_c), .dw_z(dw_z), .dw_i(dw_i), .dw_r(dw_r), .dw_q(dw_q), .dw_x(dw_x),
    .talk_active(talk_active), .listen_active(listen_active));
  gpib_ctl_model m (.clock(clock), .dio_b(dio_b), .dav_b(dav_b), .nrfd_b(nrfd_b),
    .ndac_b(ndac_b), .eoi_b(eoi_b), .ctl_dio_b(ctl_dio_b), .ctl_dav_b(ctl_dav_b),
    .ctl_nrfd_b(ctl_nrfd_b), .ctl_ndac_b(ctl_ndac_b), .atn_b(atn_b), .ifc_b(ifc_b));
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out;
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic load(input logic [7:0] b[$]);
    m.put_byte(8'h25, 1'b1);
    foreach (b[i]) m.put_byte(b[i], 1'b0);
    m.put_byte(8'h3f, 1'b1);
  endtask : load
  task automatic talk;
    int k;
    k = 0;
    m.put_byte(8'h45, 1'b1);
    while (dw_busy !== 1'b1 && k < 400) m.step_k(k);
    check({dw_busy, talk_active, listen_active}, 3'b110);
  endtask : talk
  // Data bytes in expected order, then the status byte carrying EOI
  task automatic read_back(input int n, input bit chk, input logic [23:0] ord,
                           input logic [7:0] st);
    logic [7:0] d;
    logic e;
    for (int i = 0; i < n; i++) begin
      m.get_byte(d, e);
      if (chk) check(d, ord[8*i +: 8]);
      check(e, 1'b0);
    end
    m.get_byte(d, e);
    check(d & 8'h05, st);
    check(e, 1'b1);
    m.idle();
    m.put_byte(8'h5f, 1'b1);
  endtask : read_back
  initial begin
    repeat (60000) @(posedge clock);
    error_cnt++;
    close_out();
  end
  initial begin
    logic [7:0] rd;
    logic eo;
    logic [3:0] seen;
    int k;
    repeat (8) @(posedge clock);
    #1;
    rst_b = 1'b1;
    m.step(4);
    load('{8'h11, 8'h07});
    m.put_byte(8'h99, 1'b0);
    check(listen_active, 1'b0);
    // Leading partial load must not shift the full load that follows
    load('{8'h10, 8'h03, 8'h09, 8'h11, 8'h22, 8'h33, 8'h77});
    dw_q = 1'b1;
    dw_x = 1'b1;
    dw_r = 24'habcdef;
    talk();
    check({dw_f, dw_a, dw_n}, {5'h10, 4'h3, 5'h09});
    check(dw_w, 24'h332211);
    read_back(1, 1'b1, 24'h0000ef, 8'h05);
    load('{8'h83});
    load('{8'h01});
    dw_q = 1'b0;
    dw_r = 24'h654321;
    for (int r = 1; r >= 0; r--) begin
      byte_order_rev = r[0];
      talk();
      check({dw_f, dw_a, dw_n}, {5'h01, 4'h3, 5'h09});
      check(dw_w, 24'h000000);
      read_back(3, 1'b1, r ? 24'h652143 : 24'h654321, 8'h01);
    end
    // Slow block read with clear and inhibit; Q high for two cycles, low on the third
    load('{8'hbd});
    load('{8'h00});
    dw_q = 1'b1;
    dw_r = 24'h0000c3;
    talk();
    check(dw_i, 1'b1);
    seen = '0;
    k = 0;
    while (dw_busy === 1'b1 && k < 400) begin
      seen = seen | {dw_s1, dw_s2, dw_c, dw_z};
      m.step_k(k);
    end
    check(seen, 4'b1110);
    dw_r = 24'h00003c;
    k = 0;
    while (dw_busy !== 1'b1 && k < 400) m.step_k(k);
    // At least the programmed slow gap, far below the fast one
    check(k >= 20 && k < 40, 1'b1);
    m.get_byte(rd, eo);
    check({rd, eo}, {8'hc3, 1'b0});
    dw_q = 1'b0;
    m.get_byte(rd, eo);
    check({rd, eo}, {8'h3c, 1'b1});
    m.step(50);
    check({dw_busy, talk_active}, 2'b01);
    close_out();
  end
endmodule : gpib_to_camac_command_loader_tb_top
`default_nettype wire
